// file: verilog/stop_gate.sv
// stop-mode clock gating, light-stop keep-alive decisions and address map
// Function
// RQ1 - any stop halts all peripheral clocks
// RQ2 - debug enabled keeps debug clock in stop
// RQ3 - debug enabled turns deep stop into light
// RQ4 - low-voltage stop enable turns deep into light
// RQ5 - converter runs only with async clock, detector
// RQ6 - comparator bandgap option needs detector enabled
// RQ7 - internal reference needs both enables in light
// RQ8 - crystal needs enables, high range needs detector
// RQ9 - regulator stays on with debug or detector
// RQ10 - direct page at 0x0000 to 0x007F
// RQ11 - high page at 0x1800 to 0x185F
// RQ12 - nonvolatile block at 0xFFB0 to 0xFFBF
// RQ13 - reset, software, pin interrupt vector pairs
// RQ14 - each peripheral has its own vector pair
// RQ15 - copy protect and option bytes at reset
// RQ16 - hold eight byte backdoor comparison key
// RQ17 - direct page reached by low byte
// RQ18 - single bits set, clear, test individually
// RQ19 - zero bits read zero always
// RQ20 - disabled stop gives illegal opcode reset
// RQ21 - detector in stop needs both bits
// RQ22 - one gating output per peripheral
`timescale 1ns/1ps
`include "stop_gate_consts.svh"
module stop_gate
  import stop_gate_pkg::*;
#(
  parameter int NPERIPH = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_req,
  input wire logic wake_req,
  input wire logic [7:0] nv_prot_src,
  input wire logic [7:0] nv_opt_src,
  input wire logic [63:0] nv_key_src,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_direct_addr,
  input wire vector_src_type vector_src,
  output logic illegal_opcode_reset,
  output logic [NPERIPH-1:0] periph_clk_on,
  output logic debug_clk_on,
  output logic adc_run,
  output logic analog_comparator_run,
  output logic int_ref_run,
  output logic crystal_oscillator_run,
  output logic regulator_on,
  output logic in_direct_page,
  output logic in_high_page,
  output logic in_nv_regs,
  output logic [15:0] direct_page_addr,
  output logic [15:0] vector_hi_addr,
  output logic [15:0] vector_lo_addr,
  output logic [7:0] flash_protect_byte,
  output logic [7:0] flash_option_byte
);

  logic [`CTRL_W-1:0] ctrl;
  power_mode_type mode;
  logic debug_kept;
  logic lv_kept;
  logic nv_loaded;
  logic [7:0] key [`KEY_BYTES];
  logic wr_en;
  logic lv_in_stop;
  logic deep_allowed;
  logic mapped;
  logic [31:0] next_prdata;
  logic [2:0] key_idx;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  // detector counts as enabled in stop only with both bits
  assign lv_in_stop = ctrl[`F_LV_DETECT] && ctrl[`F_LV_STOP]; // RQ21
  assign deep_allowed = ctrl[`F_DEEP_SEL] && !ctrl[`F_BKGD_DEBUG] && !lv_in_stop; // RQ3 RQ4
  assign key_idx = paddr[4:2];

  // control register: plain write plus set and clear aliases so single bits
  // can change without a read-modify-write race
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_en) begin
      case (paddr)
        `OFS_CTRL: ctrl <= pwdata[`CTRL_W-1:0];
        `OFS_CTRL_SET: ctrl <= ctrl | pwdata[`CTRL_W-1:0]; // RQ18
        `OFS_CTRL_CLR: ctrl <= ctrl & ~pwdata[`CTRL_W-1:0]; // RQ18
        default: ctrl <= ctrl;
      endcase
    end
  end

  // stop sequencing; the debug and detector enables are latched at entry, other run bits follow ctrl
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= run_mode;
      debug_kept <= 1'b0;
      lv_kept <= 1'b0;
    end else begin
      case (mode)
        run_mode: begin
          if (stop_req && ctrl[`F_STOP_INSTR]) begin
            mode <= deep_allowed ? deep_stop : light_stop; // RQ3 RQ4
            debug_kept <= ctrl[`F_BKGD_DEBUG];
            lv_kept <= lv_in_stop;
          end
        end
        light_stop, deep_stop: begin
          if (wake_req) begin
            mode <= run_mode;
            debug_kept <= 1'b0;
            lv_kept <= 1'b0;
          end
        end
        default: mode <= run_mode;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      illegal_opcode_reset <= 1'b0;
    end else begin
      illegal_opcode_reset <= (mode == run_mode) && stop_req && !ctrl[`F_STOP_INSTR]; // RQ20
    end
  end

  // gating outputs, one flop per peripheral
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_clk_on <= '1;
      debug_clk_on <= 1'b1;
      adc_run <= 1'b0;
      analog_comparator_run <= 1'b0;
      int_ref_run <= 1'b0;
      crystal_oscillator_run <= 1'b0;
      regulator_on <= 1'b1;
    end else begin
      periph_clk_on <= (mode == run_mode) ? '1 : '0; // RQ1 RQ22
      debug_clk_on <= (mode == run_mode) || (mode == light_stop && debug_kept); // RQ2
      if (mode == light_stop) begin
        adc_run <= ctrl[`F_ADC_ASYNC] && lv_kept; // RQ5
        analog_comparator_run <= !ctrl[`F_CMP_BANDGAP] || lv_kept; // RQ6
        int_ref_run <= ctrl[`F_INT_REF_ON] && ctrl[`F_INT_REF_KEEP]; // RQ7
        crystal_oscillator_run <= ctrl[`F_EXT_REF_ON] && ctrl[`F_EXT_REF_KEEP]
                                  && (!ctrl[`F_CRYSTAL_HIGH] || lv_kept); // RQ8
        regulator_on <= debug_kept || lv_kept; // RQ9
      end else if (mode == deep_stop) begin
        adc_run <= 1'b0;
        analog_comparator_run <= 1'b0;
        int_ref_run <= 1'b0;
        crystal_oscillator_run <= 1'b0;
        regulator_on <= 1'b0;
      end else begin
        adc_run <= 1'b1;
        analog_comparator_run <= 1'b1;
        int_ref_run <= ctrl[`F_INT_REF_ON];
        crystal_oscillator_run <= ctrl[`F_EXT_REF_ON];
        regulator_on <= 1'b1;
      end
    end
  end

  // nonvolatile copy happens on the first edge after release, never from the
  // async reset branch, so the source pins are sampled by a clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_loaded <= 1'b0;
      flash_protect_byte <= 8'h00;
      flash_option_byte <= 8'h00;
    end else if (!nv_loaded) begin
      nv_loaded <= 1'b1;
      flash_protect_byte <= nv_prot_src; // RQ15
      flash_option_byte <= nv_opt_src; // RQ15
    end
  end

  always_ff @(posedge pclk) begin
    if (!nv_loaded) begin
      for (int i = 0; i < `KEY_BYTES; i++) begin
        key[i] <= nv_key_src[i*8 +: 8]; // RQ16
      end
    end
  end

  // address decode of the cpu bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_direct_page <= 1'b0;
      in_high_page <= 1'b0;
      in_nv_regs <= 1'b0;
      direct_page_addr <= 16'h0000;
    end else begin
      in_direct_page <= cpu_addr <= `DP_HI; // RQ10
      in_high_page <= cpu_addr >= `HP_LO && cpu_addr <= `HP_HI; // RQ11
      in_nv_regs <= cpu_addr >= `NV_LO && cpu_addr <= `NV_HI; // RQ12
      // a short address only reaches the first 128 locations
      direct_page_addr <= `DP_LO | {9'h000, cpu_direct_addr[6:0]}; // RQ17
    end
  end

  // vector fetch: high byte first, low byte at the next address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_hi_addr <= `VEC_RESET;
      vector_lo_addr <= `VEC_RESET | 16'h0001;
    end else begin
      case (vector_src)
        src_reset: vector_hi_addr <= `VEC_RESET; // RQ13
        src_swi: vector_hi_addr <= `VEC_SWI; // RQ13
        src_irq: vector_hi_addr <= `VEC_IRQ; // RQ13
        src_low_volt: vector_hi_addr <= `VEC_LOW_VOLT;
        src_tpm1_ch0: vector_hi_addr <= `VEC_TPM1_CH0;
        src_tpm1_ch1: vector_hi_addr <= `VEC_TPM1_CH1;
        src_tpm1_ovf: vector_hi_addr <= `VEC_TPM1_OVF;
        src_tpm2_ch0: vector_hi_addr <= `VEC_TPM2_CH0;
        src_tpm2_ch1: vector_hi_addr <= `VEC_TPM2_CH1;
        src_tpm2_ovf: vector_hi_addr <= `VEC_TPM2_OVF;
        src_spi: vector_hi_addr <= `VEC_SPI; // RQ14
        src_sci_err: vector_hi_addr <= `VEC_SCI_ERR;
        src_sci_rx: vector_hi_addr <= `VEC_SCI_RX;
        src_sci_tx: vector_hi_addr <= `VEC_SCI_TX;
        src_porta: vector_hi_addr <= `VEC_PORTA;
        src_portb: vector_hi_addr <= `VEC_PORTB;
        src_adc: vector_hi_addr <= `VEC_ADC;
        src_iic: vector_hi_addr <= `VEC_IIC;
        src_rtc: vector_hi_addr <= `VEC_RTC;
        src_modulo_timer: vector_hi_addr <= `VEC_MODULO_TIMER; // RQ14
        src_comparator: vector_hi_addr <= `VEC_COMPARATOR; // RQ14
        default: vector_hi_addr <= `VEC_RESET;
      endcase
      vector_lo_addr <= {vector_hi_addr[15:1], 1'b1}; // RQ13
    end
  end

  // apb read mux; unused bits are forced to zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `OFS_CTRL, `OFS_CTRL_SET, `OFS_CTRL_CLR: next_prdata = {20'h0_0000, ctrl}; // RQ19
      `OFS_STATUS: next_prdata = {24'h00_0000, regulator_on, crystal_oscillator_run,
                                  int_ref_run, analog_comparator_run, adc_run, debug_clk_on,
                                  mode}; // RQ19
      `OFS_NV_PROT: next_prdata = {24'h00_0000, flash_protect_byte};
      `OFS_NV_OPT: next_prdata = {24'h00_0000, flash_option_byte};
      default: begin
        if (paddr >= `OFS_KEY_LO && paddr <= `OFS_KEY_HI && paddr[1:0] == 2'b00) begin
          next_prdata = {24'h00_0000, key[key_idx]}; // RQ16
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // read data is registered in the setup cycle so it is a flop in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // status, prot, opt and key are read only; writing them is an error
  assign pslverr = psel && penable && (!mapped || (pwrite && paddr != `OFS_CTRL
                   && paddr != `OFS_CTRL_SET && paddr != `OFS_CTRL_CLR));

  // ---------------- assertions ----------------
  sequence s_stop_taken;
    mode == run_mode && stop_req && ctrl[`F_STOP_INSTR];
  endsequence

  property p_clk_halt;
    @(posedge pclk) disable iff (!presetn)
      (mode != run_mode) |=> periph_clk_on == '0;
  endproperty
  a_clk_halt: assert property (p_clk_halt) else $error("peripheral clock on in stop"); // RQ1

  property p_debug_clk;
    @(posedge pclk) disable iff (!presetn)
      (mode == light_stop && debug_kept) |=> debug_clk_on && periph_clk_on == '0;
  endproperty
  a_debug_clk: assert property (p_debug_clk) else $error("debug clock lost in stop"); // RQ2

  property p_debug_light;
    @(posedge pclk) disable iff (!presetn)
      s_stop_taken ##0 ctrl[`F_BKGD_DEBUG] |=> mode == light_stop;
  endproperty
  a_debug_light: assert property (p_debug_light) else $error("deep stop with debug"); // RQ3

  property p_lv_light;
    @(posedge pclk) disable iff (!presetn)
      s_stop_taken ##0 lv_in_stop |=> mode == light_stop;
  endproperty
  a_lv_light: assert property (p_lv_light) else $error("deep stop with detector"); // RQ4

  property p_adc;
    @(posedge pclk) disable iff (!presetn)
      (mode == light_stop && !(ctrl[`F_ADC_ASYNC] && lv_kept)) |=> !adc_run;
  endproperty
  a_adc: assert property (p_adc) else $error("converter runs without its enables"); // RQ5

  property p_regulator;
    @(posedge pclk) disable iff (!presetn)
      s_stop_taken ##1 (mode == light_stop) |=> regulator_on == $past(debug_kept || lv_kept);
  endproperty
  a_regulator: assert property (p_regulator) else $error("regulator state wrong"); // RQ9

  property p_illegal;
    @(posedge pclk) disable iff (!presetn)
      (mode == run_mode && stop_req && !ctrl[`F_STOP_INSTR])
        |=> illegal_opcode_reset && mode == run_mode;
  endproperty
  a_illegal: assert property (p_illegal) else $error("disabled stop not trapped"); // RQ20

  property p_direct;
    @(posedge pclk) disable iff (!presetn)
      (cpu_addr == 16'h0080) |=> !in_direct_page;
  endproperty
  a_direct: assert property (p_direct) else $error("direct page too large"); // RQ10

  property p_nv_load;
    @(posedge pclk) disable iff (!presetn)
      $rose(nv_loaded) |-> flash_protect_byte == $past(nv_prot_src);
  endproperty
  a_nv_load: assert property (p_nv_load) else $error("protect byte not copied"); // RQ15

  property p_comparator;
    @(posedge pclk) disable iff (!presetn)
      (mode == light_stop && ctrl[`F_CMP_BANDGAP] && !lv_kept) |=> !analog_comparator_run;
  endproperty
  a_comparator: assert property (p_comparator) else $error("comparator left on"); // RQ6

  property p_int_ref;
    @(posedge pclk) disable iff (!presetn)
      (mode == light_stop && !(ctrl[`F_INT_REF_ON] && ctrl[`F_INT_REF_KEEP]))
        |=> !int_ref_run;
  endproperty
  a_int_ref: assert property (p_int_ref) else $error("internal reference left on"); // RQ7

  property p_crystal;
    @(posedge pclk) disable iff (!presetn)
      (mode == light_stop && ctrl[`F_CRYSTAL_HIGH] && !lv_kept) |=> !crystal_oscillator_run;
  endproperty
  a_crystal: assert property (p_crystal) else $error("crystal left on"); // RQ8

  property p_high_page;
    @(posedge pclk) disable iff (!presetn)
      (cpu_addr == `HP_HI + 16'h0001 || cpu_addr == `HP_LO - 16'h0001) |=> !in_high_page;
  endproperty
  a_high_page: assert property (p_high_page) else $error("high page too large"); // RQ11

  // high byte address first, the low byte address one cycle behind it
  sequence s_reset_pair;
    vector_hi_addr == `VEC_RESET ##1 vector_lo_addr == (`VEC_RESET | 16'h0001);
  endsequence

  property p_reset_vector;
    @(posedge pclk) disable iff (!presetn)
      (vector_src == src_reset) |=> s_reset_pair;
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("reset vector pair wrong"); // RQ13

endmodule

// file: common/stop_gate_consts.svh
// constants for the stop-mode gating and address map block
`ifndef STOP_GATE_CONSTS_SVH
`define STOP_GATE_CONSTS_SVH
// apb register byte offsets
`define OFS_CTRL 12'h000
`define OFS_CTRL_SET 12'h004
`define OFS_CTRL_CLR 12'h008
`define OFS_STATUS 12'h00C
`define OFS_NV_PROT 12'h010
`define OFS_NV_OPT 12'h014
`define OFS_KEY_LO 12'h020
`define OFS_KEY_HI 12'h03C
// control register fields
`define CTRL_W 12
`define CTRL_RESET 12'h000
`define F_STOP_INSTR 0
`define F_BKGD_DEBUG 1
`define F_LV_DETECT 2
`define F_LV_STOP 3
`define F_INT_REF_ON 4
`define F_INT_REF_KEEP 5
`define F_EXT_REF_ON 6
`define F_EXT_REF_KEEP 7
`define F_CRYSTAL_HIGH 8
`define F_ADC_ASYNC 9
`define F_CMP_BANDGAP 10
`define F_DEEP_SEL 11
// address regions
`define DP_LO 16'h0000
`define DP_HI 16'h007F
`define HP_LO 16'h1800
`define HP_HI 16'h185F
`define NV_LO 16'hFFB0
`define NV_HI 16'hFFBF
`define KEY_BYTES 8
// vector high-byte addresses
`define VEC_COMPARATOR 16'hFFC2
`define VEC_MODULO_TIMER 16'hFFCA
`define VEC_RTC 16'hFFCC
`define VEC_IIC 16'hFFCE
`define VEC_ADC 16'hFFD0
`define VEC_PORTB 16'hFFD4
`define VEC_PORTA 16'hFFD6
`define VEC_SCI_TX 16'hFFDA
`define VEC_SCI_RX 16'hFFDC
`define VEC_SCI_ERR 16'hFFDE
`define VEC_SPI 16'hFFE0
`define VEC_TPM2_OVF 16'hFFE2
`define VEC_TPM2_CH1 16'hFFE4
`define VEC_TPM2_CH0 16'hFFE6
`define VEC_TPM1_OVF 16'hFFE8
`define VEC_TPM1_CH1 16'hFFF2
`define VEC_TPM1_CH0 16'hFFF4
`define VEC_LOW_VOLT 16'hFFF8
`define VEC_IRQ 16'hFFFA
`define VEC_SWI 16'hFFFC
`define VEC_RESET 16'hFFFE
`endif

// file: common/stop_gate_pkg.sv
// types for the stop-mode gating and address map block
package stop_gate_pkg;
  typedef enum logic [1:0] {run_mode, light_stop, deep_stop} power_mode_type;
  typedef enum logic [4:0] {
    src_reset, src_swi, src_irq, src_low_volt, src_tpm1_ch0, src_tpm1_ch1, src_tpm1_ovf,
    src_tpm2_ch0, src_tpm2_ch1, src_tpm2_ovf, src_spi, src_sci_err, src_sci_rx,
    src_sci_tx, src_porta, src_portb, src_adc, src_iic, src_rtc, src_modulo_timer,
    src_comparator
  } vector_src_type;
endpackage

// file: testbench/stop_gate_cpu_model.sv
// cpu-side model: stop and wake pulses, address fetches, vector requests, flash contents
`timescale 1ns/1ps
module stop_gate_cpu_model
  import stop_gate_pkg::*;
#(
  parameter logic [7:0] PROT = 8'h00,
  parameter logic [7:0] OPT = 8'h00,
  parameter logic [63:0] KEY = 64'h0000_0000_0000_0000
) (
  input wire logic pclk,
  output logic stop_req,
  output logic wake_req,
  output logic [7:0] nv_prot_src,
  output logic [7:0] nv_opt_src,
  output logic [63:0] nv_key_src,
  output logic [15:0] cpu_addr,
  output logic [7:0] cpu_direct_addr,
  output vector_src_type vector_src
);
  // flash holds its contents steady from power-up on
  assign nv_prot_src = PROT;
  assign nv_opt_src = OPT;
  assign nv_key_src = KEY;
  initial begin
    stop_req = 1'b0;
    wake_req = 1'b0;
    cpu_addr = 16'h0000;
    cpu_direct_addr = 8'h00;
    vector_src = src_reset;
  end
  // one-cycle pulse; stop and wake never share a cycle
  task automatic pulse(input logic wake);
    @(posedge pclk);
    stop_req <= !wake;
    wake_req <= wake;
    @(posedge pclk);
    stop_req <= 1'b0;
    wake_req <= 1'b0;
  endtask
  // the low vector byte lags the high one, so three edges pass before returning
  task automatic fetch(input logic [15:0] a, input logic [7:0] da, input vector_src_type v);
    @(posedge pclk);
    cpu_addr <= a;
    cpu_direct_addr <= da;
    vector_src <= v;
    repeat (3) @(posedge pclk);
  endtask
endmodule

// file: testbench/stop_gate_tb_top.sv
// self-checking bench for the stop-mode gating and address map block
`timescale 1ns/1ps
`include "stop_gate_consts.svh"
module stop_gate_tb_top;
  import stop_gate_pkg::*;
  localparam int NP = 10;
  localparam logic [7:0] PROT = 8'hA5;
  localparam logic [7:0] OPT = 8'h3C;
  localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
  localparam logic [31:0] Z = 32'h0000_0000;
  localparam logic [11:0] CFG [8] = '{12'h801, 12'h803, 12'h80D, 12'h805, 12'h0F1, 12'h7D1,
    12'h7FD, 12'h061};
  localparam logic [15:0] DA [11] = '{16'h0000, 16'h007F, 16'h0080, 16'h17FF, 16'h1800,
    16'h185F, 16'h1860, 16'hFFAF, 16'hFFB0, 16'hFFBF, 16'hFFC0};
  localparam logic [2:0] DE [11] = '{3'h4, 3'h4, 3'h0, 3'h0, 3'h2, 3'h2, 3'h0, 3'h0, 3'h1,
    3'h1, 3'h0};
  localparam logic [15:0] VEC [21] = '{16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF4,
    16'hFFF2, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFE0, 16'hFFDE, 16'hFFDC, 16'hFFDA,
    16'hFFD6, 16'hFFD4, 16'hFFD0, 16'hFFCE, 16'hFFCC, 16'hFFCA, 16'hFFC2};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stop_req, wake_req;
  logic illegal_opcode_reset, debug_clk_on, adc_run, analog_comparator_run, int_ref_run;
  logic crystal_oscillator_run;
  logic regulator_on, in_direct_page, in_high_page, in_nv_regs;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [NP-1:0] periph_clk_on;
  logic [7:0] nv_prot_src, nv_opt_src, cpu_direct_addr, flash_protect_byte, flash_option_byte;
  logic [63:0] nv_key_src;
  logic [15:0] cpu_addr, direct_page_addr, vector_hi_addr, vector_lo_addr;
  vector_src_type vector_src;
  wire logic [2:0] region = {in_direct_page, in_high_page, in_nv_regs};
  int bad_count = 0;
  int comparisons = 0;
  stop_gate #(.NPERIPH(NP)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_req(stop_req), .wake_req(wake_req), .nv_prot_src(nv_prot_src),
    .nv_opt_src(nv_opt_src), .nv_key_src(nv_key_src), .cpu_addr(cpu_addr),
    .cpu_direct_addr(cpu_direct_addr), .vector_src(vector_src),
    .illegal_opcode_reset(illegal_opcode_reset), .periph_clk_on(periph_clk_on),
    .debug_clk_on(debug_clk_on), .adc_run(adc_run),
    .analog_comparator_run(analog_comparator_run), .int_ref_run(int_ref_run),
    .crystal_oscillator_run(crystal_oscillator_run), .regulator_on(regulator_on),
    .in_direct_page(in_direct_page), .in_high_page(in_high_page), .in_nv_regs(in_nv_regs),
    .direct_page_addr(direct_page_addr), .vector_hi_addr(vector_hi_addr),
    .vector_lo_addr(vector_lo_addr), .flash_protect_byte(flash_protect_byte),
    .flash_option_byte(flash_option_byte)
  );
  stop_gate_cpu_model #(.PROT(PROT), .OPT(OPT), .KEY(KEY)) cpu_u (
    .pclk(pclk), .stop_req(stop_req), .wake_req(wake_req), .nv_prot_src(nv_prot_src),
    .nv_opt_src(nv_opt_src), .nv_key_src(nv_key_src), .cpu_addr(cpu_addr),
    .cpu_direct_addr(cpu_direct_addr), .vector_src(vector_src)
  );
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer; error flag always compared, read data on reads only
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp_rd, input logic exp_err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      finish_test();
    end
    check("pslverr", 32'(exp_err), 32'(pslverr));
    if (!wr) check("prdata", exp_rd, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stop_case(input logic [11:0] c);
    logic dbg, lv, deep;
    logic [7:0] e;
    logic [5:0] s;
    dbg = c[1];
    lv = c[2] & c[3];
    deep = c[11] & !dbg & !lv;
    e = {dbg | lv, c[6] & c[7] & (!c[8] | lv), c[4] & c[5], !c[10] | lv, c[9] & lv, dbg, 2'h1};
    if (deep) e = 8'h02;
    apb(1'b1, `OFS_CTRL, {20'h0_0000, c}, Z, 1'b0);
    cpu_u.pulse(1'b0);
    repeat (2) @(posedge pclk);
    #1;
    s = {regulator_on, crystal_oscillator_run, int_ref_run, analog_comparator_run, adc_run,
         debug_clk_on};
    check("periph_clk_stop", Z, 32'(periph_clk_on));
    check("stop_outputs", 32'(e[7:2]), 32'(s));
    apb(1'b0, `OFS_STATUS, Z, 32'(e), 1'b0);
    cpu_u.pulse(1'b1);
    repeat (2) @(posedge pclk);
    #1;
    check("periph_clk_run", 32'(2 ** NP - 1), 32'(periph_clk_on));
  endtask
  initial begin
    int hi;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = Z;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    check("protect", 32'(PROT), 32'(flash_protect_byte));
    check("option", 32'(OPT), 32'(flash_option_byte));
    apb(1'b1, `OFS_CTRL, 32'hFFFF_FFFF, Z, 1'b0);
    apb(1'b0, `OFS_CTRL, Z, 32'h0000_0FFF, 1'b0);
    apb(1'b1, `OFS_CTRL_CLR, 32'h0000_0FFF, Z, 1'b0);
    apb(1'b1, `OFS_CTRL_SET, 32'h0000_0010, Z, 1'b0);
    apb(1'b0, `OFS_CTRL, Z, 32'h0000_0010, 1'b0);
    apb(1'b0, `OFS_NV_PROT, Z, 32'(PROT), 1'b0);
    apb(1'b0, `OFS_NV_OPT, Z, 32'(OPT), 1'b0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(`OFS_KEY_LO + 4 * i), Z, 32'(KEY[8 * i +: 8]), 1'b0);
    end
    apb(1'b1, `OFS_KEY_LO, 32'h0000_00FF, Z, 1'b1);
    apb(1'b0, 12'h100, Z, Z, 1'b1);
    apb(1'b0, 12'h002, Z, Z, 1'b1);
    // stop enable is clear now, so the stop must be refused
    cpu_u.pulse(1'b0);
    hi = 0;
    repeat (3) begin
      #1;
      if (illegal_opcode_reset === 1'b1) hi++;
      @(posedge pclk);
    end
    #1;
    check("illegal_pulses", 32'h0000_0001, 32'(hi));
    check("periph_clk_kept", 32'(2 ** NP - 1), 32'(periph_clk_on));
    for (int i = 0; i < 8; i++) begin
      stop_case(CFG[i]);
    end
    for (int i = 0; i < 21; i++) begin
      cpu_u.fetch(DA[i % 11], 8'(i * 13), vector_src_type'(i));
      #1;
      check("vector_hi", 32'(VEC[i]), 32'(vector_hi_addr));
      check("vector_lo", 32'(VEC[i] | 16'h0001), 32'(vector_lo_addr));
      check("decode", 32'(DE[i % 11]), 32'(region));
      check("direct_addr", 32'(i * 13 % 128), 32'(direct_page_addr));
    end
    finish_test();
  end
endmodule
